//--- cic_clock_output_pin.sv
// Purpose: Prescaled clock output with whole-period switching of settings.
// Assumes: Half period of the output is 1, 2, 4 or 8 clock cycles.
// Notes:   Settings load at the end of a full low phase or while the output is stopped, so no phase shrinks.
`timescale 1ns/1ps
module cic_clock_output_pin
    import cic_pkg::*;
(
    // Clock and control.
    input  wire logic       clock,
    input  wire logic       rst_n,
    input  wire logic       ce,
    // Settings.
    input  wire logic       en,
    input  wire logic [1:0] pre,
    input  wire logic       run,
    // Pin and event.
    output logic            pin,
    output logic            oe_n,
    output logic            rise
);
    import cic_pkg::*;

    logic [2:0] cnt_r;
    logic [1:0] pre_r;
    logic       act_r;
    logic [3:0] span;
    logic       end_ph;
    logic       load;
    logic       go;

    // Last count of a half period in the active setting (half period minus one).
    assign span   = 4'(4'h1 << pre_r) - 4'h1;
    assign end_ph = cnt_r == span[2:0];
    assign load   = !act_r || (end_ph && !pin);
    assign go     = en && run;

    // Output phases; a new setting is taken when a low phase has ended or while the output is stopped.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= 3'h0;
            pre_r <= 2'h3;
            act_r <= 1'b0;
            pin   <= 1'b0;
            oe_n  <= 1'b1;
            rise  <= 1'b0;
        end else if (ce) begin
            rise <= load && (go || act_r);   // Also marks the stop that ends the last cycle.
            if (load) begin
                act_r <= go;
                pre_r <= pre;
                oe_n  <= !en;          // Disabled leaves the pin floating.
                pin   <= go;           // Sleep with output on idles low.
                cnt_r <= 3'h0;
            end else if (end_ph) begin
                pin   <= 1'b0;
                cnt_r <= 3'h0;
            end else begin
                cnt_r <= cnt_r + 3'h1;
            end
        end
    end

endmodule

//--- cic_host.sv
// Purpose: Host model that reaches the block's registers over Avalon-MM.
// Assumes: One request at a time; the slave answers by dropping waitrequest.
// Notes:   Signals change only after a rising edge; answers are taken at the rising edge.
`timescale 1ns/1ps
module cic_host (
    // Clock and answers.
    input  wire logic        clock,
    input  wire logic        hold,
    input  wire logic        waitrequest,
    input  wire logic [31:0] readdata,
    // Requests.
    output logic      [4:0]  address,
    output logic             read,
    output logic             write,
    output logic      [31:0] writedata,
    output logic      [3:0]  byteenable
);
    // Idle bus from time zero.
    initial begin
        address = 5'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
    end

    // One access; held until waitrequest is low at a rising edge, then released.
    task automatic access(input logic wr, input logic [4:0] a, input logic [7:0] d,
                          output logic [7:0] q, output logic ok);
        int n;
        n = 0;
        // The port is deaf during start-up hold, so the host waits it out first.
        while (hold !== 1'b0 && n < 400) begin
            @(posedge clock);
            n++;
        end
        ok = (n < 400);
        @(posedge clock);
        address <= a;
        writedata <= {24'h00_0000, d};
        write <= wr;
        read <= ~wr;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (waitrequest !== 1'b0 && n < 400);
        // The completing edge: data is taken and the request released here.
        q = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        ok = ok && (n < 400);
    endtask
endmodule

//--- cic_pkg.sv
// Purpose: Shared constants and types of the interrupt, wake and clock-output block.
// Assumes: One clock; 32-bit Avalon-MM register slave with 8-bit registers and a 9-bit transmit error count.
// Notes:   Each register takes one aligned word; data sits in bits 7:0, bits 8:0 for TXCNT.
package cic_pkg;

    // Register byte offsets.
    localparam logic [4:0] CIC_OFS_CTRL  = 5'h00;
    localparam logic [4:0] CIC_OFS_STAT  = 5'h04;
    localparam logic [4:0] CIC_OFS_IEN   = 5'h08;
    localparam logic [4:0] CIC_OFS_IFLG  = 5'h0C;
    localparam logic [4:0] CIC_OFS_FAULT = 5'h10;
    localparam logic [4:0] CIC_OFS_TXCNT = 5'h14;
    localparam logic [4:0] CIC_OFS_RXCNT = 5'h18;
    localparam logic [4:0] CIC_OFS_SRST  = 5'h1C;

    // Values after reset.
    localparam logic [7:0] CIC_CTRL_RST  = 8'hE7;
    localparam logic [7:0] CIC_ZERO_RST  = 8'h00;

    // Field positions.
    localparam int CIC_CTRL_EN_BIT = 2;
    localparam int CIC_CTRL_OP_LSB = 5;
    localparam int CIC_FLG_MSG     = 7;
    localparam int CIC_FLG_WAKE    = 6;
    localparam int CIC_FLG_ERR     = 5;

    // Error counter limits.
    localparam logic [8:0] CIC_WARN_LIM = 9'h060;
    localparam logic [8:0] CIC_EP_LIM   = 9'h07F;
    localparam logic [8:0] CIC_BO_LIM   = 9'h0FF;

    // Cycle counts.
    localparam int         CIC_HOLD_CYC    = 128;
    localparam logic [7:0] CIC_HOLD_LAST   = 8'(CIC_HOLD_CYC - 1);
    localparam int         CIC_SLEEP_RISES = 16;
    localparam logic [4:0] CIC_RISE_LAST   = 5'(CIC_SLEEP_RISES - 1);

    // Operating mode codes, both requested and reported.
    localparam logic [2:0] CIC_OP_NORMAL = 3'h0;
    localparam logic [2:0] CIC_OP_SLEEP  = 3'h1;
    localparam logic [2:0] CIC_OP_LISTEN = 3'h3;
    localparam logic [2:0] CIC_OP_CONFIG = 3'h4;

    // Mode state machine.
    typedef enum logic [5:0] {
        CIC_ST_BOOT   = 6'b00_0001,
        CIC_ST_CFG    = 6'b00_0010,
        CIC_ST_RUN    = 6'b00_0100,
        CIC_ST_LISTEN = 6'b00_1000,
        CIC_ST_DRAIN  = 6'b01_0000,
        CIC_ST_SLEEP  = 6'b10_0000
    } cic_state_t;

endpackage

//--- cic_tb.sv
// Purpose: Self-checking bench for interrupt flags, fault status, sleep and clock output.
// Assumes: Host model on the register port; bus events driven here.
// Notes:   Every wait is bounded; a wait that runs out ends the run.
`timescale 1ns/1ps
module testbench;
    import cic_pkg::*;
    logic        clock = 1'b0;
    logic        reset_n = 1'b0;
    logic        msg_fault_evt = 1'b0;
    logic [1:0]  rx_overrun_evt = 2'b00;
    logic [8:0]  tx_fault_count = 9'h000;
    logic [7:0]  rx_fault_count = 8'h00;
    logic        can_rx_pin = 1'b1;
    logic [4:0]  address;
    logic        read, write, waitrequest, irq_n, clk_pin, clk_oe_n, hold;
    logic [31:0] writedata, readdata;
    logic [3:0]  byteenable;
    logic [2:0]  op_mode;
    int          bad_count = 0;
    int          check_count = 0;
    int          n, len, rises;
    logic        prev;
    logic [8:0]  tv [5] = '{9'h060, 9'h060, 9'h080, 9'h080, 9'h100};
    logic [7:0]  rv [5] = '{8'h00, 8'h60, 8'h60, 8'h80, 8'h80};
    logic [7:0]  fv [5] = '{8'h05, 8'h07, 8'h17, 8'h1F, 8'h3F};

    // Clock at 25 MHz.
    always #20 clock = ~clock;

    cic_top uut (.clock(clock), .reset_n(reset_n), .ce(1'b1), .avs_address(address),
        .avs_read(read), .avs_write(write), .avs_writedata(writedata),
        .avs_byteenable(byteenable), .avs_readdata(readdata), .avs_waitrequest(waitrequest),
        .msg_fault_evt(msg_fault_evt), .rx_overrun_evt(rx_overrun_evt),
        .other_irq_evt(5'h00), .tx_fault_count(tx_fault_count),
        .rx_fault_count(rx_fault_count), .can_rx_pin(can_rx_pin), .irq_n(irq_n),
        .clock_output_pin(clk_pin), .clock_output_pin_oe_n(clk_oe_n), .op_mode(op_mode),
        .osc_startup_timer_hold(hold));

    cic_host host (.clock(clock), .hold(hold), .waitrequest(waitrequest),
        .readdata(readdata), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable));

    // Shared verdict, reached by the main sequence and by any exhausted wait.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // A wait that used up its bound is a mismatch and ends the run.
    task automatic limit(input int used, input int bound, input string what);
        if (used >= bound) begin
            bad_count++;
            $display("wait limit reached in %s", what);
            report_and_stop();
        end
    endtask

    task automatic chk(input logic [7:0] exp, input logic [7:0] got, input string what);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic acc(input logic w, input logic [4:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        logic ok;
        host.access(w, a, d, q, ok);
        if (!ok) begin
            bad_count++;
            report_and_stop();
        end
    endtask

    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        logic [7:0] q;
        acc(1'b1, a, d, q);
    endtask

    task automatic rd(input logic [4:0] a, input logic [7:0] exp, input string what);
        logic [7:0] q;
        acc(1'b0, a, 8'h00, q);
        chk(exp, q, what);
    endtask

    task automatic edges(input int k);
        repeat (k) @(posedge clock);
    endtask

    // Length of one full high phase of the clock output, seen mid-cycle.
    task automatic high_len(output int l);
        int m;
        m = 0;
        while (clk_pin !== 1'b0 && m < 100) begin @(negedge clock); m++; end
        while (clk_pin !== 1'b1 && m < 100) begin @(negedge clock); m++; end
        limit(m, 100, "clock output edge");
        l = 0;
        while (clk_pin === 1'b1 && l < 100) begin @(negedge clock); l++; end
        limit(l, 100, "clock output high phase");
    endtask

    // Main sequence.
    initial begin
        edges(8);
        reset_n <= 1'b1;
        n = 0;
        while (hold !== 1'b0 && n < 300) begin @(posedge clock); n++; end
        limit(n, 300, "start-up hold");
        chk(8'h01, {7'h00, n >= 128 && n <= 132}, "start-up hold length");
        rd(CIC_OFS_CTRL, CIC_CTRL_RST, "control after reset");
        chk(8'h00, {7'h00, clk_oe_n}, "clock output enable after reset");
        rd(CIC_OFS_STAT, 8'h80, "status idle");
        for (int d = 0; d < 4; d++) begin
            wr(CIC_OFS_CTRL, 8'hE4 | 8'(d));
            edges(40);
            high_len(len);
            chk(8'(1 << d), 8'(len), "clock output high phase");
        end
        wr(CIC_OFS_CTRL, 8'hE3);
        edges(40);
        chk(8'h01, {7'h00, clk_oe_n}, "clock output floating");
        wr(CIC_OFS_CTRL, 8'hE7);
        edges(40);
        // Message fault held while the host tries to clear it.
        wr(CIC_OFS_IEN, 8'h80);
        msg_fault_evt <= 1'b1;
        wr(CIC_OFS_IFLG, 8'h00);
        rd(CIC_OFS_IFLG, 8'h80, "message flag");
        chk(8'h00, {7'h00, irq_n}, "interrupt line");
        msg_fault_evt <= 1'b0;
        edges(3);
        chk(8'h00, {7'h00, irq_n}, "interrupt line held");
        wr(CIC_OFS_IFLG, 8'h00);
        edges(2);
        chk(8'h01, {7'h00, irq_n}, "interrupt line released");
        // Fault thresholds, one state change at a time.
        wr(CIC_OFS_IEN, 8'h20);
        tx_fault_count <= 9'h05F;
        edges(3);
        rd(CIC_OFS_FAULT, 8'h00, "fault status below warning");
        for (int i = 0; i < 5; i++) begin
            tx_fault_count <= tv[i];
            rx_fault_count <= rv[i];
            edges(3);
            chk(8'h00, {7'h00, irq_n}, "error interrupt");
            rd(CIC_OFS_FAULT, fv[i], "fault status");
            rd(CIC_OFS_STAT, 8'h82, "source code");
            wr(CIC_OFS_IFLG, 8'h00);
            rd(CIC_OFS_IFLG, 8'h00, "error flag once");
        end
        tx_fault_count <= 9'h000;
        rx_fault_count <= 8'h00;
        rx_overrun_evt <= 2'b10;
        edges(1);
        rx_overrun_evt <= 2'b00;
        edges(2);
        rd(CIC_OFS_FAULT, 8'h80, "overrun");
        wr(CIC_OFS_IFLG, 8'h00);
        rd(CIC_OFS_IFLG, 8'h20, "error flag with overrun");
        wr(CIC_OFS_FAULT, 8'h40);
        rd(CIC_OFS_FAULT, 8'h00, "overrun cleared");
        wr(CIC_OFS_IFLG, 8'h00);
        // Sleep request, drain of the clock output, then wake on bus activity.
        wr(CIC_OFS_IEN, 8'h40);
        wr(CIC_OFS_CTRL, 8'h27);
        n = 0;
        rises = 0;
        // A rise launched by the completing edge still belongs to configuration mode.
        @(negedge clock);
        prev = clk_pin;
        while (op_mode !== CIC_OP_SLEEP && n < 1000) begin
            @(negedge clock);
            if (clk_pin === 1'b1 && prev !== 1'b1) rises++;
            prev = clk_pin;
            n++;
        end
        limit(n, 1000, "sleep entry");
        chk(8'd16, 8'(rises), "clock output rises before sleep");
        edges(20);
        chk(8'h00, {6'h00, clk_pin, clk_oe_n}, "clock output asleep");
        can_rx_pin <= 1'b0;
        edges(4);
        can_rx_pin <= 1'b1;
        edges(4);
        chk(8'h01, {7'h00, hold}, "hold after wake");
        n = 0;
        while (op_mode !== CIC_OP_LISTEN && n < 300) begin @(posedge clock); n++; end
        limit(n, 300, "listen entry");
        chk(8'h03, {5'h00, op_mode}, "mode after wake");
        rd(CIC_OFS_IFLG, 8'h40, "wake flag");
        rd(CIC_OFS_CTRL, 8'h67, "control after wake");
        chk(8'h00, {7'h00, irq_n}, "wake interrupt");
        // Soft reset returns everything to defaults.
        wr(CIC_OFS_SRST, 8'h00);
        edges(3);
        chk(8'h01, {7'h00, hold}, "hold after soft reset");
        rd(CIC_OFS_CTRL, CIC_CTRL_RST, "control after soft reset");
        rd(CIC_OFS_IFLG, 8'h00, "flags after soft reset");
        chk(8'h01, {7'h00, irq_n}, "interrupt after soft reset");
        report_and_stop();
    end
endmodule

//--- cic_top.sv
// Purpose: Interrupt flags, fault status, sleep and wake, start-up hold, clock output.
// Assumes: Protocol engine events and error counts arrive on this clock.
// Notes:   The bus-side receive pin is asynchronous and is synchronised here.
//
// The Avalon-MM interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module cic_top
    import cic_pkg::*;
(
    // Clock, reset and enable.
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        ce,
    // Avalon-MM register slave.
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Protocol engine events and counts.
    input  wire logic        msg_fault_evt,
    input  wire logic [1:0]  rx_overrun_evt,
    input  wire logic [4:0]  other_irq_evt,
    input  wire logic [8:0]  tx_fault_count,
    input  wire logic [7:0]  rx_fault_count,
    // Pins.
    input  wire logic        can_rx_pin,
    output logic             irq_n,
    output logic             clock_output_pin,
    output logic             clock_output_pin_oe_n,
    // Mode report.
    output logic [2:0]       op_mode,
    output logic             osc_startup_timer_hold
);
    import cic_pkg::*;

    logic [1:0]  rs_r;
    logic        soft_rst_r;
    logic        rst_n;
    logic [1:0]  rx_sync_r;
    logic        wreq_nxt;
    logic [7:0]  ctrl_r;
    logic [7:0]  ctrl_nxt;
    logic [7:0]  irq_enable_reg;
    logic [7:0]  irq_flag_reg;
    logic [7:0]  flag_nxt;
    logic [1:0]  ovr_r;
    logic [1:0]  ovr_nxt;
    logic [5:0]  lvl_r;
    logic [5:0]  lvl_now;
    cic_state_t  st_r;
    cic_state_t  st_nxt;
    logic [7:0]  hold_cnt_r;
    logic [4:0]  rise_cnt_r;
    logic        woke_r;
    logic        clk_rise;
    logic [2:0]  irq_source_code;
    logic [7:0]  fault_status_reg;
    logic [31:0] rd_word;
    logic [2:0]  mode_now;
    logic [7:0]  flag_set;
    logic [7:0]  cond;
    logic [7:0]  pend;

    // Pin reset and the soft reset command both empty the release chain.
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rs_r <= 2'h0;
        end else if (soft_rst_r) begin
            rs_r <= 2'h0;
        end else begin
            rs_r <= {rs_r[0], 1'b1};
        end
    end
    assign rst_n = rs_r[1];

    // The receive pin is asynchronous; only the second stage is read.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_sync_r <= 2'h3;
        end else if (ce) begin
            rx_sync_r <= {rx_sync_r[0], can_rx_pin};
        end
    end

    // Bus decode.
    wire bus_req  = avs_read || avs_write;
    wire wr_take  = avs_write && !avs_waitrequest && avs_byteenable[0];
    wire [7:0] wd = avs_writedata[7:0];
    wire sel_ctrl = avs_address == CIC_OFS_CTRL;
    wire sel_stat = avs_address == CIC_OFS_STAT;
    wire sel_ien  = avs_address == CIC_OFS_IEN;
    wire sel_iflg = avs_address == CIC_OFS_IFLG;
    wire sel_flt  = avs_address == CIC_OFS_FAULT;
    wire sel_txc  = avs_address == CIC_OFS_TXCNT;
    wire sel_rxc  = avs_address == CIC_OFS_RXCNT;
    wire sel_srst = avs_address == CIC_OFS_SRST;

    // Requests wait out the start-up hold, then finish one cycle later.
    assign wreq_nxt = !(bus_req && avs_waitrequest && !osc_startup_timer_hold);

    // Read mux; unmapped offsets read as zero.
    assign mode_now = (st_r == CIC_ST_RUN)    ? CIC_OP_NORMAL :
                      (st_r == CIC_ST_LISTEN) ? CIC_OP_LISTEN :
                      (st_r == CIC_ST_SLEEP)  ? CIC_OP_SLEEP  : CIC_OP_CONFIG;
    assign rd_word = sel_ctrl ? {24'h00_0000, ctrl_r} :
                     sel_stat ? {24'h00_0000, op_mode, 1'b0, irq_source_code, 1'b0} :
                     sel_ien  ? {24'h00_0000, irq_enable_reg} :
                     sel_iflg ? {24'h00_0000, irq_flag_reg} :
                     sel_flt  ? {24'h00_0000, fault_status_reg} :
                     sel_txc  ? {23'h00_0000, tx_fault_count} :
                     sel_rxc  ? {24'h00_0000, rx_fault_count} : 32'h0000_0000;

    // Bus handshake and read data, held at the completing edge.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            soft_rst_r      <= 1'b0;
        end else if (ce) begin
            avs_waitrequest <= wreq_nxt;
            soft_rst_r      <= wr_take && sel_srst;
            if (avs_read && avs_waitrequest) begin
                avs_readdata <= rd_word;
            end
        end
    end

    // Fault levels from the counters.
    wire rx_war  = {1'b0, rx_fault_count} >= CIC_WARN_LIM;
    wire tx_war  = tx_fault_count >= CIC_WARN_LIM;
    wire rx_pas  = {1'b0, rx_fault_count} > CIC_EP_LIM;
    wire tx_pas  = tx_fault_count > CIC_EP_LIM;
    wire bus_off = tx_fault_count > CIC_BO_LIM;
    assign lvl_now = {bus_off, tx_pas, rx_pas, tx_war, rx_war, rx_war || tx_war};
    assign fault_status_reg = {ovr_r, lvl_r};

    // Overrun bits: set by the engine, cleared only by a host write of zero.
    assign ovr_nxt = ((wr_take && sel_flt) ? (ovr_r & wd[7:6]) : ovr_r) | rx_overrun_evt;

    // Event sources; the error source fires on each level change and on each overrun event.
    wire lvl_chg   = lvl_now != lvl_r;
    wire asleep    = st_r == CIC_ST_SLEEP;
    wire activity  = !rx_sync_r[1];
    wire wake_set  = asleep && activity && irq_enable_reg[CIC_FLG_WAKE];
    assign flag_set = {msg_fault_evt, wake_set, lvl_chg || (|rx_overrun_evt), other_irq_evt};

    // A flag whose cause is still present cannot be cleared.
    assign cond = flag_set | {2'h0, |ovr_r, 5'h00};
    assign flag_nxt = (wr_take && sel_iflg) ? (wd | cond) : (irq_flag_reg | flag_set);

    // Flag and status registers; a set in the clearing cycle wins.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_flag_reg   <= CIC_ZERO_RST;
            irq_enable_reg <= CIC_ZERO_RST;
            ovr_r          <= 2'h0;
            lvl_r          <= 6'h00;
        end else if (ce) begin
            irq_flag_reg <= flag_nxt;
            ovr_r        <= ovr_nxt;
            lvl_r        <= lvl_now;
            if (wr_take && sel_ien) begin
                irq_enable_reg <= wd;
            end
        end
    end

    // Pending sources and priority code; the error source ranks first.
    assign pend = irq_flag_reg & irq_enable_reg;
    assign irq_source_code = pend[CIC_FLG_ERR]  ? 3'h1 :
                             pend[CIC_FLG_WAKE] ? 3'h2 :
                             pend[2]            ? 3'h3 :
                             pend[3]            ? 3'h4 :
                             pend[4]            ? 3'h5 :
                             pend[0]            ? 3'h6 :
                             pend[1]            ? 3'h7 : 3'h0;

    // Interrupt line: low while any enabled flag stays set.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            irq_n <= 1'b1;
        end else if (ce) begin
            irq_n <= !(|pend);
        end
    end

    // Control register; a wake rewrites the request to listen-only.
    wire boot_done = (st_r == CIC_ST_BOOT) && (hold_cnt_r == CIC_HOLD_LAST);
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (wr_take && sel_ctrl) begin
            ctrl_nxt = wd;
        end else if (boot_done && woke_r) begin
            ctrl_nxt = {CIC_OP_LISTEN, ctrl_r[4:0]};
        end
    end
    wire [2:0] req_op = ctrl_r[CIC_CTRL_OP_LSB +: 3];
    wire       clk_en = ctrl_r[CIC_CTRL_EN_BIT];
    // All sixteen drain cycles have started; the output stops after the last one.
    wire       drain_full = rise_cnt_r == 5'(CIC_SLEEP_RISES);

    // Mode state machine.
    always_comb begin
        st_nxt = st_r;
        case (st_r)
            CIC_ST_BOOT: begin
                if (boot_done) begin
                    st_nxt = woke_r ? CIC_ST_LISTEN : CIC_ST_CFG;
                end
            end
            CIC_ST_CFG, CIC_ST_RUN, CIC_ST_LISTEN: begin
                case (req_op)
                    CIC_OP_NORMAL: st_nxt = CIC_ST_RUN;
                    CIC_OP_LISTEN: st_nxt = CIC_ST_LISTEN;
                    CIC_OP_SLEEP:  st_nxt = CIC_ST_DRAIN;
                    default:       st_nxt = CIC_ST_CFG;
                endcase
            end
            CIC_ST_DRAIN: begin
                // Without a running output there is nothing to count.
                if (!clk_en || (clk_rise && drain_full)) begin
                    st_nxt = CIC_ST_SLEEP;
                end
            end
            CIC_ST_SLEEP: begin
                if (wake_set || req_op != CIC_OP_SLEEP) begin
                    st_nxt = CIC_ST_BOOT;
                end
            end
            default: st_nxt = CIC_ST_BOOT;
        endcase
    end

    // State, start-up timer and drain counter.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            st_r       <= CIC_ST_BOOT;
            ctrl_r     <= CIC_CTRL_RST;
            hold_cnt_r <= 8'h00;
            rise_cnt_r <= 5'h00;
            woke_r     <= 1'b0;
        end else if (ce) begin
            st_r   <= st_nxt;
            ctrl_r <= ctrl_nxt;
            hold_cnt_r <= (st_r == CIC_ST_BOOT) ? hold_cnt_r + 8'h01 : 8'h00;
            if (st_r != CIC_ST_DRAIN) begin
                rise_cnt_r <= 5'h00;
            end else if (clk_rise) begin
                rise_cnt_r <= rise_cnt_r + 5'h01;
            end
            if (asleep && st_nxt == CIC_ST_BOOT) begin
                woke_r <= 1'b1;
            end else if (boot_done) begin
                woke_r <= 1'b0;
            end
        end
    end

    // Mode report outputs; the hold covers reset release and every wake.
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            op_mode                <= CIC_OP_CONFIG;
            osc_startup_timer_hold <= 1'b1;
        end else if (ce) begin
            op_mode                <= mode_now;
            osc_startup_timer_hold <= st_nxt == CIC_ST_BOOT;
        end
    end

    // Clock output; it stops after the drain, in sleep and during the hold.
    cic_clock_output_pin u_clock_output_pin (
        .clock (clock),
        .rst_n (rst_n),
        .ce    (ce),
        .en    (clk_en),
        .pre   (ctrl_r[1:0]),
        .run   (!asleep && st_r != CIC_ST_BOOT && !drain_full),
        .pin   (clock_output_pin),
        .oe_n  (clock_output_pin_oe_n),
        .rise  (clk_rise)
    );

    // Checks kept beside the logic.
    property p_msg;
        @(posedge clock) disable iff (!rst_n)
        (ce && msg_fault_evt) |=> irq_flag_reg[CIC_FLG_MSG];
    endproperty
    a_msg: assert property (p_msg) else $error("Message fault flag not set.");

    property p_wake;
        @(posedge clock) disable iff (!rst_n)
        (ce && wake_set) |=> (irq_flag_reg[CIC_FLG_WAKE] && st_r == CIC_ST_BOOT);
    endproperty
    a_wake: assert property (p_wake) else $error("Wake did not flag and leave sleep.");

    property p_listen;
        @(posedge clock) disable iff (!rst_n)
        (ce && boot_done && woke_r) |=> (st_r == CIC_ST_LISTEN);
    endproperty
    a_listen: assert property (p_listen) else $error("Wake did not enter listen-only.");

    property p_err;
        @(posedge clock) disable iff (!rst_n)
        (ce && lvl_chg) |=> irq_flag_reg[CIC_FLG_ERR] && $changed(lvl_r);
    endproperty
    a_err: assert property (p_err) else $error("Error level change not flagged.");

    property p_ovr;
        @(posedge clock) disable iff (!rst_n)
        (ce && (|ovr_r) && !(wr_take && sel_flt)) |=> ((ovr_r & $past(ovr_r)) == $past(ovr_r));
    endproperty
    a_ovr: assert property (p_ovr) else $error("Overrun bit dropped by itself.");

    property p_bo;
        @(posedge clock) disable iff (!rst_n)
        (ce && tx_fault_count > 9'h0FF) |=> fault_status_reg[5] && fault_status_reg[4];
    endproperty
    a_bo: assert property (p_bo) else $error("Bus-off not reported.");

    property p_irq;
        @(posedge clock) disable iff (!rst_n)
        ce |=> (irq_n == !$past(|pend));
    endproperty
    a_irq: assert property (p_irq) else $error("Interrupt line disagrees with flags.");

    property p_sleep_low;
        @(posedge clock) disable iff (!rst_n)
        (st_r == CIC_ST_SLEEP && $past(st_r) == CIC_ST_SLEEP) |-> !clock_output_pin;
    endproperty
    a_sleep_low: assert property (p_sleep_low) else $error("Clock output high in sleep.");

    property p_boot;
        @(posedge clock) disable iff (!rst_n)
        (st_r == CIC_ST_BOOT && hold_cnt_r < CIC_HOLD_LAST) |-> osc_startup_timer_hold;
    endproperty
    a_boot: assert property (p_boot) else $error("Start-up hold released early.");

endmodule
